// file: design/alu_pkg.sv
// constants, types and opcodes for the add/logic/branch execution unit
// Behaviour
// - no suffix or word suffix: 16-bit operation
// - byte suffix: 8-bit operation
// - add carry: destination plus carry, zero source
// - add carry sets carry only on wrap
// - add writes source plus destination to destination
// - add with carry adds source, destination, carry
// - additive carry is carry out of msb
// - additive negative follows result sign
// - zero flag set when result is zero
// - additive overflow on signed overflow
// - and writes conjunction, negative msb, overflow clear
// - and/test carry is inverse of zero
// - clear bits writes not source and destination
// - clear/set bits keep all four flags
// - set bits writes source or destination
// - bit test writes nothing, flags only
// - single-bit test puts tested bit in carry
// - branch loads destination into program counter, word
// - branch accepts any mode, keeps flags
// - mode bits never altered
package alu_pkg;

  // ==========================================================
  // operations
  typedef enum logic [2:0] {
    OP_ADD,
    OP_ADD_CARRY,
    OP_ADD_WITH_CARRY,
    OP_AND,
    OP_CLEAR_BITS,
    OP_SET_BITS,
    OP_BIT_TEST,
    OP_BRANCH
  } alu_op_e;

  typedef enum logic [1:0] {
    SIZE_NONE,
    SIZE_WORD,
    SIZE_BYTE
  } size_qual_e;

  // ==========================================================
  // status word layout and reset values
  localparam int unsigned SR_C_BIT     = 0;
  localparam int unsigned SR_Z_BIT     = 1;
  localparam int unsigned SR_N_BIT     = 2;
  localparam int unsigned SR_GIE_BIT   = 3;
  localparam int unsigned SR_CORE_HALT_FLAG_BIT = 4;
  localparam int unsigned SR_OSC_HALT_FLAG_BIT = 5;
  localparam int unsigned SR_V_BIT     = 8;
  localparam logic [15:0] SR_RESET     = 16'h0000;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // ==========================================================
  // carriers
  typedef struct packed {
    alu_op_e     op;
    size_qual_e  size;
    logic [15:0] src;
    logic [15:0] dst;
  } alu_req_s;

  typedef struct packed {
    logic        n;
    logic        z;
    logic        c;
    logic        v;
  } alu_flags_s;

endpackage

// file: design/core_alu_add_logic_branch.sv
// execution unit for add, logic, bit test and branch instructions
`timescale 1ns/1ns
module core_alu_add_logic_branch (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_n_i,
  // request from operand fetch
  input  wire logic              req_valid_i,
  input  wire alu_pkg::alu_req_s req_i,
  // status word load from the core (e.g. mode bit updates elsewhere)
  input  wire logic              sr_load_i,
  input  wire logic [15:0]       sr_load_data_i,
  // results
  output logic                   wb_valid_o,
  output logic [15:0]            wb_data_o,
  output logic                   pc_load_o,
  output logic [15:0]            pc_o,
  output logic [15:0]            sr_o
);

  // ==========================================================
  // combinational datapath
  logic              byte_mode;
  logic [15:0]       s_op;
  logic [15:0]       d_op;
  logic [16:0]       sum;
  logic [15:0]       res;
  logic              cin;
  logic              msb_res;
  logic              msb_s;
  logic              msb_d;
  logic              cout;
  logic              zero;
  logic              writes;
  logic              flags_upd;
  alu_pkg::alu_flags_s fl;

  function automatic logic [15:0] size_mask(input logic bm, input logic [15:0] v);
    size_mask = bm ? {8'h00, v[7:0]} : v;
  endfunction

  assign byte_mode = (req_i.size == alu_pkg::SIZE_BYTE);
  assign cin       = sr_o[alu_pkg::SR_C_BIT];
  assign d_op      = size_mask(byte_mode, req_i.dst);
  // add carry is add with carry on a zero source
  assign s_op      = (req_i.op == alu_pkg::OP_ADD_CARRY) ? 16'h0000
                     : size_mask(byte_mode, req_i.src);

  always_comb
  begin
    sum = 17'h00000;
    res = 16'h0000;
    case (req_i.op)
      alu_pkg::OP_ADD:
      begin
        sum = {1'b0, s_op} + {1'b0, d_op};
        res = sum[15:0];
      end
      alu_pkg::OP_ADD_CARRY,
      alu_pkg::OP_ADD_WITH_CARRY:
      begin
        sum = {1'b0, s_op} + {1'b0, d_op} + {16'h0000, cin};
        res = sum[15:0];
      end
      alu_pkg::OP_AND,
      alu_pkg::OP_BIT_TEST: res = s_op & d_op;
      alu_pkg::OP_CLEAR_BITS: res = ~s_op & d_op;
      alu_pkg::OP_SET_BITS: res = s_op | d_op;
      alu_pkg::OP_BRANCH: res = req_i.dst;
      default: res = 16'h0000;
    endcase
  end

  // byte results come from bit 7 and the carry out of bit 7
  assign msb_res = byte_mode ? res[7] : res[15];
  assign msb_s   = byte_mode ? s_op[7] : s_op[15];
  assign msb_d   = byte_mode ? d_op[7] : d_op[15];
  assign cout    = byte_mode ? sum[8] : sum[16];
  assign zero    = byte_mode ? (res[7:0] == 8'h00) : (res == 16'h0000);

  always_comb
  begin
    fl        = '0;
    flags_upd = 1'b0;
    writes    = 1'b0;
    case (req_i.op)
      alu_pkg::OP_ADD,
      alu_pkg::OP_ADD_CARRY,
      alu_pkg::OP_ADD_WITH_CARRY:
      begin
        flags_upd = 1'b1;
        writes    = 1'b1;
        fl.n = msb_res;
        fl.z = zero;
        fl.c = cout;
        fl.v = (msb_s == msb_d) && (msb_res != msb_d);
      end
      alu_pkg::OP_AND,
      alu_pkg::OP_BIT_TEST:
      begin
        flags_upd = 1'b1;
        writes    = (req_i.op == alu_pkg::OP_AND);
        fl.n = msb_res;
        fl.z = zero;
        // single-bit mask: carry equals the tested bit
        fl.c = ~zero;
        fl.v = 1'b0;
      end
      alu_pkg::OP_CLEAR_BITS,
      alu_pkg::OP_SET_BITS: writes = 1'b1;
      default: writes = 1'b0;
    endcase
  end

  // ==========================================================
  // write-back
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wb_valid_o <= 1'b0;
      wb_data_o  <= alu_pkg::RESULT_RESET;
    end
    else
    begin
      wb_valid_o <= req_valid_i && writes;
      if (req_valid_i && writes)
        wb_data_o <= size_mask(byte_mode, res);
    end
  end

  // ==========================================================
  // program counter load, always a word move
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pc_load_o <= 1'b0;
      pc_o      <= alu_pkg::PC_RESET;
    end
    else
    begin
      pc_load_o <= req_valid_i && (req_i.op == alu_pkg::OP_BRANCH);
      if (req_valid_i && (req_i.op == alu_pkg::OP_BRANCH))
        pc_o <= req_i.dst;
    end
  end

  // ==========================================================
  // status word: only n, z, c, v are touched by this unit
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      sr_o <= alu_pkg::SR_RESET;
    else if (sr_load_i)
      sr_o <= sr_load_data_i;
    else if (req_valid_i && flags_upd)
    begin
      sr_o[alu_pkg::SR_N_BIT] <= fl.n;
      sr_o[alu_pkg::SR_Z_BIT] <= fl.z;
      sr_o[alu_pkg::SR_C_BIT] <= fl.c;
      sr_o[alu_pkg::SR_V_BIT] <= fl.v;  // mode bits untouched
    end
  end

  // ==========================================================
  // checks
  property p_mode_kept;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && !sr_load_i) |=>
        (sr_o[alu_pkg::SR_OSC_HALT_FLAG_BIT] == $past(sr_o[alu_pkg::SR_OSC_HALT_FLAG_BIT])) &&
        (sr_o[alu_pkg::SR_CORE_HALT_FLAG_BIT] == $past(sr_o[alu_pkg::SR_CORE_HALT_FLAG_BIT])) &&
        (sr_o[alu_pkg::SR_GIE_BIT] == $past(sr_o[alu_pkg::SR_GIE_BIT]));
  endproperty
  a_mode_kept: assert property (p_mode_kept) else $error("mode bits changed");

  property p_logic_flags_kept;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && !sr_load_i && (req_i.op inside {alu_pkg::OP_CLEAR_BITS,
        alu_pkg::OP_SET_BITS, alu_pkg::OP_BRANCH})) |=> $stable(sr_o);
  endproperty
  a_logic_flags_kept: assert property (p_logic_flags_kept) else $error("flags hit");

  property p_and_carry;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && !sr_load_i && (req_i.op inside {alu_pkg::OP_AND, alu_pkg::OP_BIT_TEST}))
      |=> (sr_o[alu_pkg::SR_C_BIT] != sr_o[alu_pkg::SR_Z_BIT]) && !sr_o[alu_pkg::SR_V_BIT];
  endproperty
  a_and_carry: assert property (p_and_carry) else $error("and carry wrong");

  property p_test_no_wb;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && req_i.op == alu_pkg::OP_BIT_TEST) |=> !wb_valid_o;
  endproperty
  a_test_no_wb: assert property (p_test_no_wb) else $error("bit test wrote back");

  property p_branch_pc;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && req_i.op == alu_pkg::OP_BRANCH) |=> pc_load_o && (pc_o == $past(req_i.dst));
  endproperty
  a_branch_pc: assert property (p_branch_pc) else $error("branch target wrong");

  property p_add_word;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && req_i.op == alu_pkg::OP_ADD && req_i.size != alu_pkg::SIZE_BYTE)
      |=> wb_valid_o && (wb_data_o == 16'($past(req_i.src) + $past(req_i.dst)));
  endproperty
  a_add_word: assert property (p_add_word) else $error("word add result wrong");

  property p_byte_upper;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    // bit test and branch leave the held result alone
      (req_valid_i && req_i.size == alu_pkg::SIZE_BYTE &&
       !(req_i.op inside {alu_pkg::OP_BIT_TEST, alu_pkg::OP_BRANCH}))
      |=> (wb_data_o[15:8] == 8'h00);
  endproperty
  a_byte_upper: assert property (p_byte_upper) else $error("byte upper bits set");

  property p_adc_wrap;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && !sr_load_i && req_i.op == alu_pkg::OP_ADD_CARRY)
      |=> (sr_o[alu_pkg::SR_C_BIT] ==
           ((wb_data_o == 16'h0000) && $past(sr_o[alu_pkg::SR_C_BIT])));
  endproperty
  a_adc_wrap: assert property (p_adc_wrap) else $error("add carry flag wrong");

  property p_no_branch_idle;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (!req_valid_i) |=> !pc_load_o && !wb_valid_o;
  endproperty
  a_no_branch_idle: assert property (p_no_branch_idle) else $error("idle output");

  // word add: a carry out leaves the sum below the source
  property p_add_cout;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && !sr_load_i && req_i.op == alu_pkg::OP_ADD &&
       req_i.size != alu_pkg::SIZE_BYTE)
      |=> (sr_o[alu_pkg::SR_C_BIT] == (wb_data_o < $past(req_i.src)));
  endproperty
  a_add_cout: assert property (p_add_cout) else $error("add carry wrong");

  property p_byte_cout;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && !sr_load_i && req_i.op == alu_pkg::OP_ADD &&
       req_i.size == alu_pkg::SIZE_BYTE)
      |=> (sr_o[alu_pkg::SR_C_BIT] == (wb_data_o[7:0] < $past(req_i.src[7:0])));
  endproperty
  a_byte_cout: assert property (p_byte_cout) else $error("byte carry wrong");

  property p_add_ovf;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && !sr_load_i && req_i.op == alu_pkg::OP_ADD &&
       req_i.size != alu_pkg::SIZE_BYTE)
      |=> (sr_o[alu_pkg::SR_V_BIT] == (($past(req_i.src[15]) == $past(req_i.dst[15])) &&
          (wb_data_o[15] != $past(req_i.dst[15]))));
  endproperty
  a_add_ovf: assert property (p_add_ovf) else $error("add overflow wrong");

  property p_add_nz;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && !sr_load_i && (req_i.op inside {alu_pkg::OP_ADD, alu_pkg::OP_ADD_CARRY,
        alu_pkg::OP_ADD_WITH_CARRY}))
      |=> (sr_o[alu_pkg::SR_Z_BIT] == (wb_data_o == 16'h0000)) &&
          (sr_o[alu_pkg::SR_N_BIT] == (($past(req_i.size) == alu_pkg::SIZE_BYTE) ?
          wb_data_o[7] : wb_data_o[15]));
  endproperty
  a_add_nz: assert property (p_add_nz) else $error("add n or z wrong");

  property p_ac_sum;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && req_i.op == alu_pkg::OP_ADD_CARRY && req_i.size != alu_pkg::SIZE_BYTE)
      |=> wb_valid_o &&
          (wb_data_o == $past(req_i.dst) + {15'h0000, $past(sr_o[alu_pkg::SR_C_BIT])});
  endproperty
  a_ac_sum: assert property (p_ac_sum) else $error("add carry sum wrong");

  property p_awc_sum;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && req_i.op == alu_pkg::OP_ADD_WITH_CARRY &&
       req_i.size != alu_pkg::SIZE_BYTE)
      |=> wb_valid_o && (wb_data_o == $past(req_i.src) + $past(req_i.dst) +
          {15'h0000, $past(sr_o[alu_pkg::SR_C_BIT])});
  endproperty
  a_awc_sum: assert property (p_awc_sum) else $error("add with carry sum wrong");

  property p_and_data;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && req_i.op == alu_pkg::OP_AND && req_i.size != alu_pkg::SIZE_BYTE)
      |=> wb_valid_o && (wb_data_o == ($past(req_i.src) & $past(req_i.dst)));
  endproperty
  a_and_data: assert property (p_and_data) else $error("and result wrong");

  property p_clear_data;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && req_i.op == alu_pkg::OP_CLEAR_BITS && req_i.size != alu_pkg::SIZE_BYTE)
      |=> wb_valid_o && (wb_data_o == (~$past(req_i.src) & $past(req_i.dst)));
  endproperty
  a_clear_data: assert property (p_clear_data) else $error("clear result wrong");

  property p_set_data;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && req_i.op == alu_pkg::OP_SET_BITS && req_i.size != alu_pkg::SIZE_BYTE)
      |=> wb_valid_o && (wb_data_o == ($past(req_i.src) | $past(req_i.dst)));
  endproperty
  a_set_data: assert property (p_set_data) else $error("set result wrong");

  property p_branch_no_wb;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_valid_i && req_i.op == alu_pkg::OP_BRANCH) |=> !wb_valid_o;
  endproperty
  a_branch_no_wb: assert property (p_branch_no_wb) else $error("branch wrote back");

  // mode bits only ever change through the core's own load
  property p_load_wins;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      sr_load_i |=> (sr_o == $past(sr_load_data_i));
  endproperty
  a_load_wins: assert property (p_load_wins) else $error("status load lost");

endmodule

// file: test/testbench.sv
// self-checking bench for the add, logic, bit test and branch execution unit
`timescale 1ns/1ns
module testbench;
  // ==========================================================
  // stimulus rows
  typedef struct packed {
    alu_pkg::alu_op_e    op;
    alu_pkg::size_qual_e size;
    logic [15:0]         src;
    logic [15:0]         dst;
    logic [15:0]         sr_in;
    logic [15:0]         exp_d;
    logic [15:0]         exp_sr;
  } row_s;
  localparam alu_pkg::size_qual_e SN = alu_pkg::SIZE_NONE;
  localparam alu_pkg::size_qual_e SW = alu_pkg::SIZE_WORD;
  localparam alu_pkg::size_qual_e SB = alu_pkg::SIZE_BYTE;
  localparam alu_pkg::alu_op_e    O_ADD    = alu_pkg::OP_ADD;
  localparam alu_pkg::alu_op_e    O_AC     = alu_pkg::OP_ADD_CARRY;
  localparam alu_pkg::alu_op_e    O_AWC    = alu_pkg::OP_ADD_WITH_CARRY;
  localparam alu_pkg::alu_op_e    O_AND    = alu_pkg::OP_AND;
  localparam alu_pkg::alu_op_e    O_CLR    = alu_pkg::OP_CLEAR_BITS;
  localparam alu_pkg::alu_op_e    O_SET    = alu_pkg::OP_SET_BITS;
  localparam alu_pkg::alu_op_e    O_TST    = alu_pkg::OP_BIT_TEST;
  localparam alu_pkg::alu_op_e    O_BRANCH = alu_pkg::OP_BRANCH;
  row_s rows [17] = '{
    '{O_ADD, SN, 16'h0001, 16'h0002, 16'h0000, 16'h0003, 16'h0000},
    '{O_ADD, SW, 16'h0001, 16'h7FFF, 16'h0038, 16'h8000, 16'h013C},
    '{O_ADD, SB, 16'h00FF, 16'h1201, 16'h0000, 16'h0000, 16'h0003},
    '{O_AC, SW, 16'h1234, 16'hFFFF, 16'h0001, 16'h0000, 16'h0003},
    '{O_AC, SB, 16'h0000, 16'h55FF, 16'h0001, 16'h0000, 16'h0003},
    '{O_AC, SW, 16'h0000, 16'h7FFF, 16'h0001, 16'h8000, 16'h0104},
    '{O_AC, SB, 16'h0000, 16'h00FE, 16'h0001, 16'h00FF, 16'h0004},
    '{O_AWC, SW, 16'h0001, 16'h0001, 16'h0001, 16'h0003, 16'h0000},
    '{O_AWC, SB, 16'h0040, 16'h003F, 16'h0001, 16'h0080, 16'h0104},
    '{O_AND, SW, 16'hAA55, 16'hF00F, 16'h0100, 16'hA005, 16'h0005},
    '{O_AND, SB, 16'h0080, 16'hFF80, 16'h0000, 16'h0080, 16'h0005},
    '{O_AND, SW, 16'h00FF, 16'hFF00, 16'h0001, 16'h0000, 16'h0002},
    '{O_CLR, SW, 16'hFC00, 16'hFFFF, 16'h013F, 16'h03FF, 16'h013F},
    '{O_SET, SB, 16'h00E0, 16'hFF01, 16'h0000, 16'h00E1, 16'h0000},
    '{O_TST, SB, 16'h0008, 16'h0008, 16'h0000, 16'h0000, 16'h0001},
    '{O_TST, SW, 16'h0200, 16'h0000, 16'h0001, 16'h0000, 16'h0002},
    '{O_BRANCH, SN, 16'h0000, 16'hFFFE, 16'h013F, 16'hFFFE, 16'h013F}
  };
  // ==========================================================
  // design signals
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              req_valid = 1'b0;
  alu_pkg::alu_req_s req = '0;
  logic              sr_load = 1'b0;
  logic [15:0]       sr_load_data = 16'h0000;
  logic              wb_valid;
  logic [15:0]       wb_data;
  logic              pc_load;
  logic [15:0]       pc;
  logic [15:0]       sr;
  int                fails = 0;
  int                compares = 0;
  int                cycles = 0;
  logic [15:0]       last_d = 16'h0000;
  logic              wr;
  logic              br;

  core_alu_add_logic_branch u_dut (
    .core_clk_i    (clk),
    .reset_n_i     (reset_n),
    .req_valid_i   (req_valid),
    .req_i         (req),
    .sr_load_i     (sr_load),
    .sr_load_data_i(sr_load_data),
    .wb_valid_o    (wb_valid),
    .wb_data_o     (wb_data),
    .pc_load_o     (pc_load),
    .pc_o          (pc),
    .sr_o          (sr)
  );

  always #25 clk = ~clk;

  // ==========================================================
  // helpers
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // hang guard well beyond the roughly 80 cycles the tests need
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 2000)
    begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares = compares + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic load_sr(input logic [15:0] v);
    @(posedge clk);
    #1 sr_load = 1'b1;
    sr_load_data = v;
    @(posedge clk);
    #1 sr_load = 1'b0;
  endtask

  task automatic issue(input alu_pkg::alu_op_e op, input alu_pkg::size_qual_e sz,
                       input logic [15:0] s, input logic [15:0] d);
    @(posedge clk);
    #1 req_valid = 1'b1;
    req = '{op, sz, s, d};
  endtask

  task automatic settle();
    @(posedge clk);
    #1 req_valid = 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    #1 chk(sr | pc | wb_data, 16'h0000, "reset outputs");
    chk({14'h0000, wb_valid, pc_load}, 16'h0000, "reset pulses");
    reset_n = 1'b1;
    $display("reset done");
    foreach (rows[i])
    begin
      load_sr(rows[i].sr_in);
      issue(rows[i].op, rows[i].size, rows[i].src, rows[i].dst);
      settle();
      wr = !(rows[i].op inside {alu_pkg::OP_BIT_TEST, alu_pkg::OP_BRANCH});
      br = rows[i].op == alu_pkg::OP_BRANCH;
      chk({15'h0000, wb_valid}, {15'h0000, wr}, "wb_valid");
      chk(wb_data, wr ? rows[i].exp_d : last_d, "wb_data");
      chk({15'h0000, pc_load}, {15'h0000, br}, "pc_load");
      if (br)
        chk(pc, rows[i].exp_d, "pc");
      chk(sr, rows[i].exp_sr, "status");
      if (wr)
        last_d = rows[i].exp_d;
      $display("row %0d done", i);
    end
    // back to back carry chain, then an idle cycle with a stale request
    load_sr(16'h0000);
    issue(alu_pkg::OP_ADD, SW, 16'hFFFF, 16'h0001);
    issue(alu_pkg::OP_ADD_WITH_CARRY, SW, 16'h0000, 16'h0000);
    chk(sr, 16'h0003, "chain first flags");
    settle();
    chk(wb_data, 16'h0001, "chain carry in");
    chk(sr, 16'h0000, "chain second flags");
    @(posedge clk);
    #1 chk({15'h0000, wb_valid}, 16'h0000, "pulse length");
    $display("carry chain done");
    // status load wins over the flag update of the same edge
    sr_load = 1'b1;
    sr_load_data = 16'h0038;
    req_valid = 1'b1;
    req = '{alu_pkg::OP_ADD, SW, 16'h8000, 16'h8000};
    settle();
    sr_load = 1'b0;
    chk(sr, 16'h0038, "load priority");
    chk(wb_data, 16'h0000, "load with add");
    $display("load priority done");
    // reset in mid run clears outputs at once
    reset_n = 1'b0;
    #1 chk(sr | pc | wb_data, 16'h0000, "mid reset");
    chk({14'h0000, wb_valid, pc_load}, 16'h0000, "mid reset pulses");
    @(posedge clk);
    // request taken at the first edge after release; carry in must be clear
    #1 reset_n = 1'b1;
    req_valid = 1'b1;
    req = '{alu_pkg::OP_ADD_WITH_CARRY, SW, 16'h0005, 16'h0006};
    settle();
    chk({15'h0000, wb_valid}, 16'h0001, "first after reset");
    chk(wb_data, 16'h000B, "sum after reset");
    chk(sr, 16'h0000, "flags after reset");
    $display("mid reset done");
    tally_and_finish();
  end
endmodule
